// ### verilog/adcsq_pkg.sv
// Purpose: constants and types for the converter sequencer/trigger block
// Assumes: 200 MHz clock, four sequencers, eight analog inputs
// Notes:   Summary list below; offsets are byte addresses on AXI4-Lite
package adcsq_pkg;
  localparam int NSEQ     = 4;
  localparam int NCH      = 8;
  localparam int SW       = 10;
  localparam int RW       = 12;
  localparam int FDEPTH   = 4;
  localparam int NPWM     = 6;

  // Conversion time per sample (1 MSPS) and clock period
  localparam int CONV_TIME_NS = 1000;
  localparam int CLK_PER_NS   = 5;
  localparam int CONV_CYCLES  = (CONV_TIME_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam logic [1:0] WARMUP_CONV = 2'h2;

  localparam logic [7:0] OFS_SEQ_EN    = 8'h00;
  localparam logic [7:0] OFS_RAW_IRQ   = 8'h04;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLR   = 8'h0C;
  localparam logic [7:0] OFS_EMUX      = 8'h10;
  localparam logic [7:0] OFS_PROC_TRIG = 8'h14;
  localparam logic [7:0] OFS_AVG       = 8'h18;
  localparam logic [7:0] OFS_SEQ_CFG   = 8'h1C;
  localparam logic [7:0] OFS_FIFO0     = 8'h20;
  localparam logic [7:0] OFS_FIFO_STAT = 8'h30;
  localparam logic [7:0] OFS_PWM_TRIG  = 8'h34;
  localparam logic [7:0] OFS_PWM_STAT  = 8'h38;

  localparam logic [3:0] SRC_PROCESSOR = 4'h0;
  localparam logic [3:0] SRC_TIMER0    = 4'h1;
  localparam logic [3:0] SRC_TIMER3    = 4'h4;
  localparam logic [3:0] SRC_PWM       = 4'h5;
  localparam logic [3:0] SRC_ALWAYS    = 4'hF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       diff;
    logic [2:0] chan;
  } adcsq_seqcfg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01
  } adcsq_state_t;
endpackage

// ### verilog/adcsq_avg.sv
// Purpose: one conversion run with optional hardware averaging
// Assumes: inputs synchronous; start only while not busy
// Notes:   signed accumulate, arithmetic shift divide
`timescale 1ns/10ps
module adcsq_avg (
  // Clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              reset_i,
  // Run control
  input  wire logic                              start_i,
  input  wire adcsq_pkg::adcsq_seqcfg_t          cfg_i,
  input  wire logic [1:0]                        avg_log2_i,
  // Analog inputs
  input  wire logic [adcsq_pkg::NCH-1:0][adcsq_pkg::SW-1:0] ain_i,
  // Result
  output logic                                   busy_o,
  output logic                                   done_o,
  output logic [adcsq_pkg::RW-1:0]               result_o
);
  import adcsq_pkg::*;

  adcsq_seqcfg_t      cfg_q;
  logic [1:0]         log_q;
  logic [7:0]         tick;
  logic [3:0]         left;
  logic signed [15:0] acc;
  logic signed [RW-1:0] mn;
  logic signed [RW-1:0] mx;

  wire [2:0] pos_idx = {cfg_q.chan[2:1], 1'b0};
  wire [2:0] neg_idx = {cfg_q.chan[2:1], 1'b1};
  // Any of the eight inputs can be picked
  wire signed [RW-1:0] single_s = $signed({2'h0, ain_i[cfg_q.chan]});
  wire signed [RW-1:0] diff_s = $signed({2'h0, ain_i[pos_idx]})
                              - $signed({2'h0, ain_i[neg_idx]});
  wire signed [RW-1:0] sample_s = cfg_q.diff ? diff_s : single_s;
  wire signed [15:0] next_acc = acc + 16'(sample_s);
  wire tick_end = busy_o && (tick == 8'(CONV_CYCLES - 1));
  // Signed shift keeps near-zero differential averages exact
  wire signed [15:0] next_avg = next_acc >>> log_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_o   <= 1'b0;
      done_o   <= 1'b0;
      result_o <= 12'h000;
      cfg_q    <= '0;
      log_q    <= 2'h0;
      tick     <= 8'h00;
      left     <= 4'h0;
      acc      <= 16'h0000;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        busy_o <= 1'b1;
        cfg_q  <= cfg_i;
        log_q  <= avg_log2_i;
        tick   <= 8'h00;
        left   <= 4'(4'h1 << avg_log2_i);
        acc    <= 16'h0000;
      end else if (tick_end) begin
        tick <= 8'h00;
        acc  <= next_acc;
        left <= left - 4'h1;
        if (left == 4'h1) begin
          busy_o   <= 1'b0;
          done_o   <= 1'b1;
          result_o <= next_avg[RW-1:0];
        end
      end else if (busy_o) begin
        tick <= tick + 8'h01;
      end
    end
  end

  // Range of samples seen in this run, for checking only
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mn <= 12'h7FF;
      mx <= 12'h800;
    end else if (start_i && !busy_o) begin
      mn <= 12'h7FF;
      mx <= 12'h800;
    end else if (tick_end) begin
      mn <= (sample_s < mn) ? sample_s : mn;
      mx <= (sample_s > mx) ? sample_s : mx;
    end
  end

  a_avg_in_range: assert property (@(posedge clk_i) disable iff (reset_i)
    done_o |-> ($signed(result_o) >= mn && $signed(result_o) <= mx))
    else $error("average outside sample range");

  c_avg_diff: cover property (@(posedge clk_i) disable iff (reset_i)
    done_o && cfg_q.diff && log_q != 2'h0);
endmodule // adcsq_avg

// ### verilog/adcsq_top.sv
// Purpose: trigger selection, sequencing, FIFOs and interrupts
// Assumes: AXI4-Lite master keeps one read and one write outstanding
// Notes:   sequencer 0 has highest priority for the shared converter
`timescale 1ns/10ps
module adcsq_top (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  // AXI4-Lite write
  input  wire logic [7:0]              s_axi_awaddr_i,
  input  wire logic                    s_axi_awvalid_i,
  output logic                         s_axi_awready_o,
  input  wire logic [31:0]             s_axi_wdata_i,
  input  wire logic [3:0]              s_axi_wstrb_i,
  input  wire logic                    s_axi_wvalid_i,
  output logic                         s_axi_wready_o,
  output logic [1:0]                   s_axi_bresp_o,
  output logic                         s_axi_bvalid_o,
  input  wire logic                    s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [7:0]              s_axi_araddr_i,
  input  wire logic                    s_axi_arvalid_i,
  output logic                         s_axi_arready_o,
  output logic [31:0]                  s_axi_rdata_o,
  output logic [1:0]                   s_axi_rresp_o,
  output logic                         s_axi_rvalid_o,
  input  wire logic                    s_axi_rready_i,
  // Trigger sources
  input  wire logic [3:0]              timer_trig_i,
  input  wire logic [adcsq_pkg::NPWM-1:0] pwm_evt_i,
  // Analog inputs
  input  wire logic [adcsq_pkg::NCH-1:0][adcsq_pkg::SW-1:0] ain_i,
  // Interrupt
  output logic                         irq_o
);
  import adcsq_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic                  aw_full;
  logic                  w_full;
  logic [7:0]            aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic [NSEQ-1:0]       seq_enable;
  logic [NSEQ-1:0]       irq_enable;
  logic [NSEQ-1:0]       raw_irq;
  logic [15:0]           event_mux_select;
  logic [1:0]            avg_log2;
  adcsq_seqcfg_t [NSEQ-1:0] seq_cfg;
  logic [NPWM-1:0]       pwm_gen_int_trigger_enable;
  logic [NPWM-1:0]       pwm_gen_int_status_clear;
  logic [NSEQ-1:0]       pend;
  logic [1:0]            warm_cnt;
  logic [1:0]            cur;
  adcsq_state_t          state;
  logic                  eng_busy;
  logic                  eng_done;
  logic [RW-1:0]         eng_result;
  logic [NSEQ-1:0]       trig;
  logic [NSEQ-1:0]       fifo_empty;
  logic [NSEQ-1:0]       fifo_full;
  logic [NSEQ-1:0][RW-1:0] fifo_head;

  ////////////////////////////////////////////////////////////////////////
  // Write path: address and data may arrive in either order
  wire        wr_go = aw_full && w_full && !s_axi_bvalid_o;
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                       {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] wbits = w_data & wmask;
  wire we_seq_en  = wr_go && aw_addr == OFS_SEQ_EN;
  wire we_irq_en  = wr_go && aw_addr == OFS_IRQ_EN;
  wire we_irq_clr = wr_go && aw_addr == OFS_IRQ_CLR;
  wire we_emux    = wr_go && aw_addr == OFS_EMUX;
  wire we_proc    = wr_go && aw_addr == OFS_PROC_TRIG;
  wire we_avg     = wr_go && aw_addr == OFS_AVG;
  wire we_cfg     = wr_go && aw_addr == OFS_SEQ_CFG;
  wire we_pwm_en  = wr_go && aw_addr == OFS_PWM_TRIG;
  wire we_pwm_clr = wr_go && aw_addr == OFS_PWM_STAT;
  wire wr_hit = we_seq_en | we_irq_en | we_irq_clr | we_emux | we_proc
              | we_avg | we_cfg | we_pwm_en | we_pwm_clr;
  wire [31:0] merge_seq_en = ({28'h0, seq_enable} & ~wmask) | wbits;
  wire [31:0] merge_irq_en = ({28'h0, irq_enable} & ~wmask) | wbits;
  wire [31:0] merge_emux   = ({16'h0, event_mux_select} & ~wmask) | wbits;
  wire [31:0] merge_avg    = ({30'h0, avg_log2} & ~wmask) | wbits;
  wire [31:0] merge_cfg    = ({16'h0, seq_cfg} & ~wmask) | wbits;
  wire [31:0] merge_pwm_en = ({26'h0, pwm_gen_int_trigger_enable} & ~wmask)
                           | wbits;
  wire [NSEQ-1:0] proc_trig = we_proc ? wbits[NSEQ-1:0] : 4'h0;
  wire [NSEQ-1:0] irq_clr   = we_irq_clr ? wbits[NSEQ-1:0] : 4'h0;
  wire [NPWM-1:0] pwm_clr   = we_pwm_clr ? wbits[NPWM-1:0] : 6'h00;

  assign s_axi_awready_o = !aw_full && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_full && !s_axi_bvalid_o;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      aw_full        <= 1'b0;
      w_full         <= 1'b0;
      aw_addr        <= 8'h00;
      w_data         <= 32'h0000_0000;
      w_strb         <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_full        <= 1'b0;
        w_full         <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path; a FIFO data read pops that FIFO
  wire ar_go = s_axi_arvalid_i && s_axi_arready_o;
  wire [7:0] ra = s_axi_araddr_i;
  wire [1:0] ra_seq = ra[3:2];
  wire ra_fifo = ra[7:4] == OFS_FIFO0[7:4] && ra[1:0] == 2'h0;
  wire [NSEQ-1:0] pop = (ar_go && ra_fifo) ? (4'h1 << ra_seq) & ~fifo_empty
                                            : 4'h0;
  wire ra_hit = ra_fifo || ra == OFS_SEQ_EN || ra == OFS_RAW_IRQ
              || ra == OFS_IRQ_EN || ra == OFS_IRQ_CLR || ra == OFS_EMUX
              || ra == OFS_PROC_TRIG || ra == OFS_AVG || ra == OFS_SEQ_CFG
              || ra == OFS_FIFO_STAT || ra == OFS_PWM_TRIG
              || ra == OFS_PWM_STAT;
  // Write-only registers read as zero
  wire [31:0] rd_word =
      ra_fifo ? 32'(signed'(fifo_head[ra_seq])) :
      ra == OFS_SEQ_EN    ? {28'h0, seq_enable} :
      ra == OFS_RAW_IRQ   ? {28'h0, raw_irq} :
      ra == OFS_IRQ_EN    ? {28'h0, irq_enable} :
      ra == OFS_EMUX      ? {16'h0, event_mux_select} :
      ra == OFS_AVG       ? {30'h0, avg_log2} :
      ra == OFS_SEQ_CFG   ? {16'h0, seq_cfg} :
      ra == OFS_FIFO_STAT ? {24'h0, fifo_full, fifo_empty} :
      ra == OFS_PWM_TRIG  ? {26'h0, pwm_gen_int_trigger_enable} :
      ra == OFS_PWM_STAT  ? {26'h0, pwm_gen_int_status_clear} :
      32'h0000_0000;

  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= RESP_OKAY;
    end else if (ar_go) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= rd_word;
      s_axi_rresp_o  <= ra_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers and sticky status
  wire warming = warm_cnt < WARMUP_CONV;
  wire accept  = eng_done && !warming && seq_enable[cur];
  wire [NSEQ-1:0] push = accept ? 4'h1 << cur : 4'h0;
  // Each enabled PWM event fires regardless of its status bit
  wire pwm_fire = |(pwm_evt_i & pwm_gen_int_trigger_enable);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      seq_enable                 <= 4'h0;
      irq_enable                 <= 4'h0;
      event_mux_select           <= 16'h0000;
      avg_log2                   <= 2'h0;
      seq_cfg                    <= '0;
      pwm_gen_int_trigger_enable <= 6'h00;
      raw_irq                    <= 4'h0;
      pwm_gen_int_status_clear   <= 6'h00;
    end else begin
      if (we_seq_en) seq_enable <= merge_seq_en[NSEQ-1:0];
      if (we_irq_en) irq_enable <= merge_irq_en[NSEQ-1:0];
      if (we_emux) event_mux_select <= merge_emux[15:0];
      if (we_avg) avg_log2 <= merge_avg[1:0];
      if (we_cfg) seq_cfg <= merge_cfg[15:0];
      if (we_pwm_en) pwm_gen_int_trigger_enable <= merge_pwm_en[NPWM-1:0];
      // Set wins over a clear in the same cycle
      raw_irq <= (raw_irq & ~irq_clr) | push;
      // One status bit per PWM condition
      pwm_gen_int_status_clear <= (pwm_gen_int_status_clear & ~pwm_clr)
                                | pwm_evt_i;
    end
  end

  assign irq_o = |(raw_irq & irq_enable);

  ////////////////////////////////////////////////////////////////////////
  // Per-sequencer trigger, pending flag and FIFO
  wire [NSEQ-1:0] cand = pend & seq_enable & ~fifo_full;
  wire [1:0] sel = cand[0] ? 2'h0 : cand[1] ? 2'h1 : cand[2] ? 2'h2 : 2'h3;
  wire start = state == ST_IDLE && |cand && !eng_busy;
  wire redo  = eng_done && warming;

  genvar s;
  generate
    for (s = 0; s < NSEQ; s++) begin : g_seq
      logic [RW-1:0] mem [FDEPTH];
      logic [1:0]    wp;
      logic [1:0]    rp;
      logic [2:0]    cnt;
      wire  [3:0]    code = event_mux_select[4*s +: 4];
      wire  is_timer = code >= SRC_TIMER0 && code <= SRC_TIMER3;
      wire  [1:0]    tsel = 2'(code - SRC_TIMER0);
      // Only the selected timer's own pulse counts
      wire  src_hit =
          code == SRC_PROCESSOR ? proc_trig[s] :
          is_timer              ? timer_trig_i[tsel] :
          code == SRC_PWM       ? pwm_fire :
          code == SRC_ALWAYS;
      assign trig[s] = seq_enable[s] && src_hit;
      assign fifo_empty[s] = cnt == 3'h0;
      assign fifo_full[s]  = cnt == 3'(FDEPTH);
      assign fifo_head[s]  = mem[rp];

      // A retrigger in flight queues one run, no more
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          pend[s] <= 1'b0;
        end else if (trig[s] || (redo && cur == 2'(s))) begin
          pend[s] <= 1'b1;
        end else if (start && sel == 2'(s)) begin
          pend[s] <= 1'b0;
        end
      end

      // Every accepted conversion is stored
      always_ff @(posedge clk_i) begin
        if (push[s]) mem[wp] <= eng_result;
      end

      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          wp  <= 2'h0;
          rp  <= 2'h0;
          cnt <= 3'h0;
        end else begin
          if (push[s]) wp <= wp + 2'h1;
          if (pop[s]) rp <= rp + 2'h1;
          cnt <= cnt + 3'(push[s]) - 3'(pop[s]);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Converter ownership
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state    <= ST_IDLE;
      cur      <= 2'h0;
      warm_cnt <= 2'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_CONV;
            cur   <= sel;
          end
        end
        ST_CONV: begin
          if (eng_done) begin
            state <= ST_IDLE;
            // Results before warm-up ends are dropped
            if (warming) warm_cnt <= warm_cnt + 2'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  adcsq_avg u_avg (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .start_i    (start),
    .cfg_i      (seq_cfg[sel]),
    .avg_log2_i (avg_log2),
    .ain_i      (ain_i),
    .busy_o     (eng_busy),
    .done_o     (eng_done),
    .result_o   (eng_result)
  );

  ////////////////////////////////////////////////////////////////////////
  a_always_code: assert property (@(posedge clk_i) disable iff (reset_i)
    (seq_enable[3] && event_mux_select[15:12] == SRC_ALWAYS) |-> trig[3])
    else $error("always code did not trigger sequencer three");
  a_always_fills: assert property (@(posedge clk_i) disable iff (reset_i)
    push[3] |=> !fifo_empty[3])
    else $error("sequencer three FIFO empty after store");
  a_timer_gate: assert property (@(posedge clk_i) disable iff (reset_i)
    (trig[0] && g_seq[0].is_timer) |-> timer_trig_i[g_seq[0].tsel])
    else $error("timer trigger without its own pulse");
  a_retrig_queue: assert property (@(posedge clk_i) disable iff (reset_i)
    (state == ST_CONV && trig[cur]) |=> pend[$past(cur)])
    else $error("retrigger lost or not queued");
  a_pwm_every: assert property (@(posedge clk_i) disable iff (reset_i)
    (seq_enable[1] && event_mux_select[7:4] == SRC_PWM && pwm_fire)
      |-> trig[1])
    else $error("pwm match did not trigger");
  a_pwm_status: assert property (@(posedge clk_i) disable iff (reset_i)
    (|pwm_evt_i) |=> ((pwm_gen_int_status_clear & $past(pwm_evt_i))
                      == $past(pwm_evt_i)))
    else $error("pwm status bit missed its event");
  a_timer3_trig: assert property (@(posedge clk_i) disable iff (reset_i)
    (seq_enable[2] && event_mux_select[11:8] == SRC_TIMER3
      && timer_trig_i[3]) |-> trig[2])
    else $error("timer three did not trigger");
  a_data_first: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(raw_irq[0]) |-> !fifo_empty[0])
    else $error("interrupt before FIFO data");
  a_warmup_drop: assert property (@(posedge clk_i) disable iff (reset_i)
    (eng_done && warming) |-> push == 4'h0 ##1 warm_cnt == $past(warm_cnt) + 2'h1)
    else $error("warm-up conversion was stored");

  c_always_run: cover property (@(posedge clk_i) disable iff (reset_i)
    push[3] && event_mux_select[15:12] == SRC_ALWAYS);
  c_pwm_start: cover property (@(posedge clk_i) disable iff (reset_i)
    pwm_fire ##[1:4] start);
  c_retrig: cover property (@(posedge clk_i) disable iff (reset_i)
    state == ST_CONV && trig[cur]);
endmodule // adcsq_top

// ### dv/adcsq_src_model.sv
// Purpose: analog inputs and trigger sources facing the block
// Assumes: tasks are called just after a rising edge
// Notes:   every pulse lasts exactly one clock
`timescale 1ns/10ps
module adcsq_src_model (
  // Clock
  input  wire logic                                    clk_i,
  // Sources
  output logic [adcsq_pkg::NCH-1:0][adcsq_pkg::SW-1:0] ain_o,
  output logic [3:0]                                   tmr_o,
  output logic [adcsq_pkg::NPWM-1:0]                   pwm_o
);
  import adcsq_pkg::*;
  initial begin
    ain_o = '0;
    tmr_o = '0;
    pwm_o = '0;
  end
  task automatic set_ain(input int ch, input int v);
    ain_o[ch] <= SW'(v);
  endtask
  task automatic hold_tmr(input int k, input logic v);
    tmr_o[k] <= v;
  endtask
  // Bit k of the event bus pairs with status bit k
  task automatic pulse(input logic is_pwm, input int k);
    @(posedge clk_i);
    if (is_pwm) pwm_o[k] <= 1'b1;
    else tmr_o[k] <= 1'b1;
    @(posedge clk_i);
    if (is_pwm) pwm_o[k] <= 1'b0;
    else tmr_o[k] <= 1'b0;
  endtask
endmodule // adcsq_src_model

// ### dv/test_adc_sequencer_trigger_control.sv
// Purpose: self-checking bench for the sequencer and trigger block
// Assumes: AXI4-Lite master, one transfer at a time
// Notes:   expected samples kept in a queue, popped per FIFO read
`timescale 1ns/10ps
module test_adc_sequencer_trigger_control;
  import adcsq_pkg::*;
  logic clk_i, reset_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  logic s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, irq_o;
  logic [7:0]             s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0]            s_axi_wdata_i, s_axi_rdata_o, rd, e;
  logic [1:0]             s_axi_bresp_o, s_axi_rresp_o, resp;
  logic [3:0]             timer_trig_i;
  logic [NPWM-1:0]        pwm_evt_i;
  logic [NCH-1:0][SW-1:0] ain_i;
  int fail_count, num_checks, c, n, k, d, av[8], exp_q[$];

  adcsq_top i_dut (.clk_i, .reset_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .timer_trig_i,
    .pwm_evt_i, .ain_i, .irq_o);
  adcsq_src_model i_src (.clk_i, .ain_o(ain_i), .tmr_o(timer_trig_i),
    .pwm_o(pwm_evt_i));

  always #2.5 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // Ready sampled half a cycle early; it cannot move before the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    logic h_aw, h_w, h_b;
    h_b = 1'b0;
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= dt;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    while (!h_b) begin
      @(negedge clk_i);
      h_aw = s_axi_awready_o;
      h_w = s_axi_wready_o;
      h_b = s_axi_bvalid_o;
      resp = s_axi_bresp_o;
      @(posedge clk_i);
      if (h_aw) s_axi_awvalid_i <= 1'b0;
      if (h_w) s_axi_wvalid_i <= 1'b0;
      if (h_b) s_axi_bready_i <= 1'b0;
    end
  endtask
  task automatic rdr(input logic [7:0] a);
    logic h_ar, h_r;
    h_r = 1'b0;
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    while (!h_r) begin
      @(negedge clk_i);
      h_ar = s_axi_arready_o;
      h_r = s_axi_rvalid_o;
      rd = s_axi_rdata_o;
      resp = s_axi_rresp_o;
      @(posedge clk_i);
      if (h_ar) s_axi_arvalid_i <= 1'b0;
      if (h_r) s_axi_rready_i <= 1'b0;
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    rdr(a);
    chk(rd, x);
  endtask
  task automatic fifo_chk(input int s);
    rdr(OFS_FIFO0 + 8'(4 * s));
    e = exp_q.pop_front();
    chk(32'(rd[11:0]), e & 32'hFFF);
  endtask
  task automatic irq_is(input logic v);
    @(negedge clk_i);
    for (n = 0; n < 3000 && irq_o !== v; n++) @(negedge clk_i);
    chk(32'(irq_o), 32'(v));
  endtask
  task automatic sa(input int ch, input int v);
    av[ch] = v;
    i_src.set_ain(ch, v);
  endtask
  task final_report;
    $display("checks=%0d failures=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    fail_count++;
    final_report;
  end

  initial begin
    {clk_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = '0;
    {s_axi_arvalid_i, s_axi_rready_i, s_axi_awaddr_i, s_axi_araddr_i} = '0;
    s_axi_wdata_i = '0;
    reset_i = 1'b1;
    void'($urandom(43524));
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    rdc(OFS_FIFO_STAT, 32'h0F);
    rdc(8'h3C, 32'h0);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(8'h3C, 32'hFFFFFFFF);
    chk(32'(resp), 32'(RESP_SLVERR));
    c = $urandom % 8;
    for (k = 0; k < 8; k++) sa(k, $urandom % 512);
    wr(OFS_IRQ_EN, 32'hF);
    wr(OFS_SEQ_CFG, {16'h0, 4'h1, 4'h0, 4'hC, 1'b0, 3'(c)});
    wr(OFS_EMUX, 32'h0400);
    wr(OFS_SEQ_EN, 32'h7);
    // First run also absorbs the two warm-up conversions
    exp_q = {av[c], av[c], av[c]};
    wr(OFS_PROC_TRIG, 32'h1);
    repeat (700) @(posedge clk_i);
    rdc(OFS_FIFO_STAT, 32'h0E);
    // Retrigger in mid-run: one extra run, never continuous
    wr(OFS_PROC_TRIG, 32'h1);
    wr(OFS_PROC_TRIG, 32'h1);
    repeat (600) @(posedge clk_i);
    rdc(OFS_FIFO_STAT, 32'h0E);
    repeat (3) fifo_chk(0);
    rdc(OFS_FIFO_STAT, 32'h0F);
    rdc(OFS_RAW_IRQ, 32'h1);
    wr(OFS_IRQ_CLR, 32'h1);
    irq_is(1'b0);
    // Averaged differential results around zero
    wr(OFS_AVG, 32'h2);
    for (d = -1; d < 2; d++) begin
      sa(4, 300 + d);
      sa(5, 300);
      exp_q.push_back(d);
      wr(OFS_PROC_TRIG, 32'h2);
      irq_is(1'b1);
      fifo_chk(1);
      wr(OFS_IRQ_CLR, 32'h2);
    end
    wr(OFS_AVG, 32'h0);
    // Timer three while another timer stays active
    i_src.hold_tmr(0, 1'b1);
    exp_q.push_back(av[0]);
    i_src.pulse(1'b0, 3);
    irq_is(1'b1);
    fifo_chk(2);
    repeat (600) @(posedge clk_i);
    rdc(OFS_FIFO_STAT, 32'h0F);
    i_src.hold_tmr(0, 1'b0);
    wr(OFS_IRQ_CLR, 32'h4);
    // Every PWM condition, status left set between events
    wr(OFS_EMUX, 32'h0405);
    for (k = 0; k < NPWM; k++) begin
      wr(OFS_PWM_TRIG, 32'(1 << k));
      repeat (2) begin
        exp_q.push_back(av[c]);
        i_src.pulse(1'b1, k);
        irq_is(1'b1);
        fifo_chk(0);
        wr(OFS_IRQ_CLR, 32'h1);
      end
      rdc(OFS_PWM_STAT, 32'(1 << k));
      wr(OFS_PWM_STAT, 32'(1 << k));
      rdc(OFS_PWM_STAT, 32'h0);
    end
    // Always sampling on sequencer three fills its FIFO
    wr(OFS_EMUX, 32'hF405);
    wr(OFS_SEQ_EN, 32'hF);
    rdr(OFS_FIFO_STAT);
    for (n = 0; n < 400 && rd[7] !== 1'b1; n++) rdr(OFS_FIFO_STAT);
    chk(rd & 32'h88, 32'h80);
    wr(OFS_SEQ_EN, 32'h7);
    rdc(OFS_RAW_IRQ, 32'h8);
    wr(OFS_IRQ_EN, 32'h7);
    irq_is(1'b0);
    wr(OFS_IRQ_CLR, 32'h8);
    wr(OFS_IRQ_EN, 32'hF);
    repeat (4) begin
      exp_q.push_back(av[1]);
      fifo_chk(3);
    end
    rdc(OFS_FIFO_STAT, 32'h0F);
    final_report;
  end
endmodule // test_adc_sequencer_trigger_control
